// ===== pkg/dsc_pkg.sv
// Shared constants and types for the asynchronous serial channel.
package dsc_pkg;
  // Register addresses on the three address lines.
  localparam logic [2:0] ADDR_DATA   = 3'h0;
  localparam logic [2:0] ADDR_IER    = 3'h1;
  localparam logic [2:0] ADDR_IIR    = 3'h2;
  localparam logic [2:0] ADDR_LFMT   = 3'h3;
  localparam logic [2:0] ADDR_MCTL   = 3'h4;
  localparam logic [2:0] ADDR_LSTAT  = 3'h5;
  localparam logic [2:0] ADDR_MSTAT  = 3'h6;
  localparam logic [2:0] ADDR_SCR    = 3'h7;
  // Line format field positions.
  localparam int LF_STOP  = 2;
  localparam int LF_PEN   = 3;
  localparam int LF_EVEN  = 4;
  localparam int LF_STICK = 5;
  localparam int LF_BRK   = 6;
  localparam int LF_DIVISOR_ACCESS_BIT  = 7;
  // Modem control field positions.
  localparam int MC_DTR   = 0;
  localparam int MC_RTS   = 1;
  localparam int MC_OP1   = 2;
  localparam int MC_OP2   = 3;
  localparam int MC_LOOP  = 4;
  // Interrupt enable field positions.
  localparam int IE_RX    = 0;
  localparam int IE_TX    = 1;
  localparam int IE_LS    = 2;
  localparam int IE_MS    = 3;
  // Interrupt identification codes.
  localparam logic [7:0] IIR_NONE = 8'h01;
  localparam logic [7:0] IIR_LS   = 8'h06;
  localparam logic [7:0] IIR_RX   = 8'h04;
  localparam logic [7:0] IIR_TX   = 8'h02;
  localparam logic [7:0] IIR_MS   = 8'h00;
  // Values after reset.
  localparam logic [3:0]  IER_RST  = 4'h0;
  localparam logic [7:0]  LFMT_RST = 8'h00;
  localparam logic [4:0]  MCTL_RST = 5'h00;
  localparam logic [7:0]  SCR_RST  = 8'h00;
  localparam logic [15:0] DIV_RST  = 16'h0000;
  // Counts of 16x ticks.
  localparam logic [5:0] TICK_BIT_END = 6'h0F;
  localparam logic [5:0] RX_MID_TICK  = 6'h07;
  localparam logic [5:0] STOP1_TICKS  = 6'h10;
  localparam logic [5:0] STOP15_TICKS = 6'h18;
  localparam logic [5:0] STOP2_TICKS  = 6'h20;
  typedef enum logic [2:0] {SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP} dsc_ser_e;
endpackage

// ===== pkg/dsc_baud_if.sv
// Carrier between the channel and its baud generator.
`timescale 1ns/1ns
interface dsc_baud_if #(parameter int DIV_W = 16);
  logic [DIV_W-1:0] divisor;
  logic             tick;
  modport gen  (input divisor, output tick);
  modport user (output divisor, input tick);
endinterface

// ===== design/dsc_baud_gen.sv
// Baud generator producing the 16x bit tick from the divisor latch.
`timescale 1ns/1ns
module dsc_baud_gen #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Divisor in, tick out
  dsc_baud_if.gen  baud
);
  logic [DIV_W-1:0] cnt_r;
  logic             tick_r;

  if (DIV_W < 2) begin : g_chk
    $error("dsc_baud_gen: DIV_W must be at least 2");
  end

  assign baud.tick = tick_r;

  // A zero divisor stops the generator, so a freshly reset channel stays quiet.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (clkEn) begin
      if (baud.divisor == '0) begin
        cnt_r  <= '0;
        tick_r <= 1'b0;
      end else if (cnt_r >= baud.divisor - DIV_W'(1)) begin
        cnt_r  <= '0;
        tick_r <= 1'b1;
      end else begin
        cnt_r  <= cnt_r + DIV_W'(1);
        tick_r <= 1'b0;
      end
    end
  end
endmodule

// ===== design/dsc_channel.sv
// One asynchronous serial channel with modem control and host register port.
`timescale 1ns/1ns
module dsc_channel #(
  parameter int DATA_W = 8,
  parameter int DIV_W  = 16
) (
  // Clock, reset and enable
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  // Host register port
  input  wire logic              csN,
  input  wire logic [2:0]        addr,
  input  wire logic              rdN,
  input  wire logic              wrN,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic      [DATA_W-1:0] dataOut,
  output logic                   interruptOut,
  // Serial line
  input  wire logic              serialReceiveIn,
  output logic                   serialTransmitOut,
  // Modem lines
  input  wire logic              ctsN,
  input  wire logic              dsrN,
  input  wire logic              ringInN,
  input  wire logic              carrierInN,
  output logic                   dtrN,
  output logic                   rtsN,
  output logic                   generalPurposeOutN
);
  if (DATA_W != 8 || DIV_W != 16) begin : g_chk
    $error("dsc_channel: only DATA_W 8 and DIV_W 16 are supported");
  end

  logic [3:0]        ier_r;
  logic [7:0]        lfmt_r;
  logic [4:0]        mctl_r;
  logic [7:0]        scr_r;
  logic [15:0]       divisor_r;
  logic              rdPrev_r, wrPrev_r;
  logic [7:0]        dataOut_r;
  logic              intOut_r, serOut_r, dtrN_r, rtsN_r, op2N_r;
  dsc_pkg::dsc_ser_e txSt_r, rxSt_r;
  logic [7:0]        thr_r, tsr_r, rxShift_r, rhr_r;
  logic              thrEmpty_r, txLine_r, txPar_r, thrIntPend_r;
  logic [5:0]        txCnt_r, rxCnt_r;
  logic [2:0]        txBit_r, rxBit_r;
  logic              rxPrev_r, rxParS_r, rxZero_r, dr_r;
  logic [3:0]        errs_r;
  logic [3:0]        msPrev_r, delta_r;
  logic              primed_r;

  dsc_baud_if #(.DIV_W(DIV_W)) baudIf ();
  assign baudIf.divisor = divisor_r;

  dsc_baud_gen #(.DIV_W(DIV_W)) u_baud (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .baud    (baudIf.gen)
  );

  // Host strobes are taken on their first low cycle, so a long strobe acts once.
  logic sel, rdEv, wrEv, divisor_access_bit, wrThr, rdRhr, rdIir, rdLsr, rdMsr, wrIer;
  assign sel   = !csN;
  assign rdEv  = sel && !rdN && rdPrev_r;
  assign wrEv  = sel && !wrN && wrPrev_r;
  assign divisor_access_bit  = lfmt_r[dsc_pkg::LF_DIVISOR_ACCESS_BIT];
  assign wrThr = wrEv && addr == dsc_pkg::ADDR_DATA && !divisor_access_bit;
  assign wrIer = wrEv && addr == dsc_pkg::ADDR_IER && !divisor_access_bit;
  assign rdRhr = rdEv && addr == dsc_pkg::ADDR_DATA && !divisor_access_bit;
  assign rdIir = rdEv && addr == dsc_pkg::ADDR_IIR;
  assign rdLsr = rdEv && addr == dsc_pkg::ADDR_LSTAT;
  assign rdMsr = rdEv && addr == dsc_pkg::ADDR_MSTAT;

  // Character format shared by both directions.
  logic [1:0] wordLen;
  logic [2:0] lastBit;
  logic [7:0] dataMask;
  logic [5:0] stopTicks;
  logic       pen, loopMode, tick;
  assign wordLen  = lfmt_r[1:0];
  assign lastBit  = {1'b1, wordLen};
  assign dataMask = 8'(8'hFF >> (2'd3 - wordLen));
  assign pen      = lfmt_r[dsc_pkg::LF_PEN];
  assign loopMode = mctl_r[dsc_pkg::MC_LOOP];
  assign tick     = baudIf.tick;
  assign stopTicks = !lfmt_r[dsc_pkg::LF_STOP] ? dsc_pkg::STOP1_TICKS :
                     (wordLen == 2'b00 ? dsc_pkg::STOP15_TICKS : dsc_pkg::STOP2_TICKS);

  function automatic logic parOf(input logic [7:0] d);
    if (lfmt_r[dsc_pkg::LF_STICK]) begin
      return !lfmt_r[dsc_pkg::LF_EVEN];
    end
    return lfmt_r[dsc_pkg::LF_EVEN] ? ^d : ~^d;
  endfunction

  // Register writes.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ier_r     <= dsc_pkg::IER_RST;
      lfmt_r    <= dsc_pkg::LFMT_RST;
      mctl_r    <= dsc_pkg::MCTL_RST;
      scr_r     <= dsc_pkg::SCR_RST;
      divisor_r <= dsc_pkg::DIV_RST;
    end else if (clkEn && wrEv) begin
      unique case (addr)
        dsc_pkg::ADDR_DATA: if (divisor_access_bit) divisor_r[7:0] <= dataIn;
        dsc_pkg::ADDR_IER: begin
          if (divisor_access_bit) divisor_r[15:8] <= dataIn;
          else ier_r <= dataIn[3:0];
        end
        dsc_pkg::ADDR_LFMT: lfmt_r <= dataIn;
        dsc_pkg::ADDR_MCTL: mctl_r <= dataIn[4:0];
        dsc_pkg::ADDR_SCR:  scr_r  <= dataIn;
        default: ;
      endcase
    end
  end

  // Transmitter. A write while the holding register is full is dropped.
  logic txLoad;
  assign txLoad = tick && txSt_r == dsc_pkg::SER_IDLE && !thrEmpty_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      txSt_r     <= dsc_pkg::SER_IDLE;
      txLine_r   <= 1'b1;
      thr_r      <= '0;
      tsr_r      <= '0;
      thrEmpty_r <= 1'b1;
      txCnt_r    <= '0;
      txBit_r    <= '0;
      txPar_r    <= 1'b0;
    end else if (clkEn) begin
      if (wrThr && thrEmpty_r) begin
        thr_r      <= dataIn;
        thrEmpty_r <= 1'b0;
      end
      if (tick) begin
        txCnt_r <= txCnt_r + 6'h01;
        unique case (txSt_r)
          dsc_pkg::SER_IDLE: begin
            txCnt_r <= '0;
            if (!thrEmpty_r) begin
              tsr_r      <= thr_r & dataMask;
              txPar_r    <= parOf(thr_r & dataMask);
              thrEmpty_r <= 1'b1;
              txLine_r   <= 1'b0;
              txSt_r     <= dsc_pkg::SER_START;
            end
          end
          dsc_pkg::SER_START: if (txCnt_r == dsc_pkg::TICK_BIT_END) begin
            txCnt_r  <= '0;
            txBit_r  <= '0;
            txLine_r <= tsr_r[0];
            txSt_r   <= dsc_pkg::SER_DATA;
          end
          dsc_pkg::SER_DATA: if (txCnt_r == dsc_pkg::TICK_BIT_END) begin
            txCnt_r <= '0;
            if (txBit_r == lastBit) begin
              txLine_r <= pen ? txPar_r : 1'b1;
              txSt_r   <= pen ? dsc_pkg::SER_PAR : dsc_pkg::SER_STOP;
            end else begin
              txBit_r  <= txBit_r + 3'h1;
              tsr_r    <= tsr_r >> 1;
              txLine_r <= tsr_r[1];
            end
          end
          dsc_pkg::SER_PAR: if (txCnt_r == dsc_pkg::TICK_BIT_END) begin
            txCnt_r  <= '0;
            txLine_r <= 1'b1;
            txSt_r   <= dsc_pkg::SER_STOP;
          end
          dsc_pkg::SER_STOP: if (txCnt_r == stopTicks - 6'h01) begin
            txSt_r <= dsc_pkg::SER_IDLE;
          end
          default: txSt_r <= dsc_pkg::SER_IDLE;
        endcase
      end
    end
  end

  // Interrupt sources and identification.
  logic       lsPend, rxPend, txPend, msPend, anyPend;
  logic [7:0] iirVal, lsrVal, msrVal;
  logic [3:0] msNow;
  assign lsPend  = ier_r[dsc_pkg::IE_LS] && |errs_r;
  assign rxPend  = ier_r[dsc_pkg::IE_RX] && dr_r;
  assign txPend  = ier_r[dsc_pkg::IE_TX] && thrIntPend_r;
  assign msPend  = ier_r[dsc_pkg::IE_MS] && |delta_r;
  assign anyPend = lsPend || rxPend || txPend || msPend;
  assign iirVal  = lsPend ? dsc_pkg::IIR_LS : rxPend ? dsc_pkg::IIR_RX :
                   txPend ? dsc_pkg::IIR_TX : msPend ? dsc_pkg::IIR_MS : dsc_pkg::IIR_NONE;

  // Transmit-empty interrupt: set on transfer or on enabling while empty; set wins.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      thrIntPend_r <= 1'b0;
    end else if (clkEn) begin
      if (txLoad || (wrIer && dataIn[dsc_pkg::IE_TX] && !ier_r[dsc_pkg::IE_TX] && thrEmpty_r)) begin
        thrIntPend_r <= 1'b1;
      end else if (wrThr || (rdIir && iirVal == dsc_pkg::IIR_TX)) begin
        thrIntPend_r <= 1'b0;
      end
    end
  end

  // Receiver. The input is taken synchronous; loopback feeds the transmit line in.
  logic rxIn, rxDone, rxExpect;
  logic [7:0] rxData;
  assign rxIn   = loopMode ? txLine_r : serialReceiveIn;
  assign rxDone = tick && rxSt_r == dsc_pkg::SER_STOP && rxCnt_r == dsc_pkg::TICK_BIT_END;
  assign rxData = 8'(rxShift_r >> (2'd3 - wordLen));
  assign rxExpect = parOf(rxData);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rxSt_r    <= dsc_pkg::SER_IDLE;
      rxPrev_r  <= 1'b1;
      rxCnt_r   <= '0;
      rxBit_r   <= '0;
      rxShift_r <= '0;
      rxParS_r  <= 1'b0;
      rxZero_r  <= 1'b0;
    end else if (clkEn) begin
      rxPrev_r <= rxIn;
      if (rxSt_r == dsc_pkg::SER_IDLE) begin
        rxCnt_r <= '0;
        if (rxPrev_r && !rxIn) rxSt_r <= dsc_pkg::SER_START;
      end else if (tick) begin
        rxCnt_r <= rxCnt_r + 6'h01;
        unique case (rxSt_r)
          dsc_pkg::SER_START: if (rxCnt_r == dsc_pkg::RX_MID_TICK) begin
            rxCnt_r  <= '0;
            rxBit_r  <= '0;
            rxZero_r <= 1'b1;
            rxSt_r   <= rxIn ? dsc_pkg::SER_IDLE : dsc_pkg::SER_DATA;
          end
          dsc_pkg::SER_DATA: if (rxCnt_r == dsc_pkg::TICK_BIT_END) begin
            rxCnt_r   <= '0;
            rxShift_r <= {rxIn, rxShift_r[7:1]};
            rxZero_r  <= rxZero_r && !rxIn;
            rxBit_r   <= rxBit_r + 3'h1;
            if (rxBit_r == lastBit) begin
              rxSt_r <= pen ? dsc_pkg::SER_PAR : dsc_pkg::SER_STOP;
            end
          end
          dsc_pkg::SER_PAR: if (rxCnt_r == dsc_pkg::TICK_BIT_END) begin
            rxCnt_r  <= '0;
            rxParS_r <= rxIn;
            rxSt_r   <= dsc_pkg::SER_STOP;
          end
          dsc_pkg::SER_STOP: if (rxCnt_r == dsc_pkg::TICK_BIT_END) begin
            rxSt_r <= dsc_pkg::SER_IDLE;
          end
          default: rxSt_r <= dsc_pkg::SER_IDLE;
        endcase
      end
    end
  end

  // Receive holding and line status flags; a new event beats a clearing read.
  logic [3:0] errSet;
  assign errSet = rxDone ? {rxZero_r && !rxIn && !(pen && rxParS_r),
                            !rxIn, pen && rxParS_r != rxExpect, dr_r} : 4'h0;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rhr_r  <= '0;
      dr_r   <= 1'b0;
      errs_r <= '0;
    end else if (clkEn) begin
      if (rxDone) begin
        rhr_r <= rxData;
        dr_r  <= 1'b1;
      end else if (rdRhr) begin
        dr_r <= 1'b0;
      end
      errs_r <= errSet | (rdLsr ? 4'h0 : errs_r);
    end
  end
  assign lsrVal = {1'b0, thrEmpty_r && txSt_r == dsc_pkg::SER_IDLE, thrEmpty_r, errs_r, dr_r};

  // Modem status. The first cycle after reset only primes the previous levels.
  assign msNow = loopMode ? {mctl_r[dsc_pkg::MC_OP2], mctl_r[dsc_pkg::MC_OP1],
                             mctl_r[dsc_pkg::MC_DTR], mctl_r[dsc_pkg::MC_RTS]} :
                            {!carrierInN, !ringInN, !dsrN, !ctsN};
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      msPrev_r <= '0;
      primed_r <= 1'b0;
      delta_r  <= '0;
    end else if (clkEn) begin
      msPrev_r <= msNow;
      primed_r <= 1'b1;
      delta_r  <= (primed_r ? {msPrev_r[3] ^ msNow[3], msPrev_r[2] && !msNow[2],
                               msPrev_r[1:0] ^ msNow[1:0]} : 4'h0) | (rdMsr ? 4'h0 : delta_r);
    end
  end
  assign msrVal = {msNow, delta_r};

  // Host read data and strobe history.
  logic [7:0] rdVal;
  always_comb begin
    rdVal = 8'h00;
    unique case (addr)
      dsc_pkg::ADDR_DATA:  rdVal = divisor_access_bit ? 8'h00 : rhr_r;
      dsc_pkg::ADDR_IIR:   rdVal = iirVal;
      dsc_pkg::ADDR_LSTAT: rdVal = lsrVal;
      dsc_pkg::ADDR_MSTAT: rdVal = msrVal;
      dsc_pkg::ADDR_SCR:   rdVal = scr_r;
      default:             rdVal = 8'h00;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdPrev_r  <= 1'b1;
      wrPrev_r  <= 1'b1;
      dataOut_r <= 8'h00;
    end else if (clkEn) begin
      rdPrev_r <= !(sel && !rdN);
      wrPrev_r <= !(sel && !wrN);
      if (rdEv) dataOut_r <= rdVal;
    end
  end

  // Pins. Break and loopback override the transmit line here, after the shifter.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      serOut_r <= 1'b1;
      dtrN_r   <= 1'b1;
      rtsN_r   <= 1'b1;
      op2N_r   <= 1'b1;
      intOut_r <= 1'b0;
    end else if (clkEn) begin
      serOut_r <= loopMode ? 1'b1 : (lfmt_r[dsc_pkg::LF_BRK] ? 1'b0 : txLine_r);
      dtrN_r   <= !mctl_r[dsc_pkg::MC_DTR];
      rtsN_r   <= !mctl_r[dsc_pkg::MC_RTS];
      op2N_r   <= !mctl_r[dsc_pkg::MC_OP2];
      intOut_r <= anyPend;
    end
  end
  assign dataOut            = dataOut_r;
  assign interruptOut       = intOut_r;
  assign serialTransmitOut  = serOut_r;
  assign dtrN               = dtrN_r;
  assign rtsN               = rtsN_r;
  assign generalPurposeOutN = op2N_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_prio_line;
    lsPend |-> iirVal == 8'h06;
  endproperty
  a_prio_line: assert property (p_prio_line) else $error("line status not top priority");
  property p_iir_none;
    !anyPend |-> iirVal == 8'h01;
  endproperty
  a_iir_none: assert property (p_iir_none) else $error("idle identification not 01");
  property p_break_out;
    clkEn && lfmt_r[6] && !mctl_r[4] |=> !serialTransmitOut;
  endproperty
  a_break_out: assert property (p_break_out) else $error("break not holding output low");
  property p_loop_out;
    clkEn && mctl_r[4] ##1 clkEn && mctl_r[4] |=> serialTransmitOut [*1];
  endproperty
  a_loop_out: assert property (p_loop_out) else $error("loopback output not high");
  property p_dtr_pin;
    clkEn |=> dtrN == !$past(mctl_r[0]);
  endproperty
  a_dtr_pin: assert property (p_dtr_pin) else $error("terminal-ready pin wrong");
  property p_lsr_top;
    lsrVal[7] == 1'b0 && (lsrVal[6] -> lsrVal[5]);
  endproperty
  a_lsr_top: assert property (p_lsr_top) else $error("line status bits 6/7 inconsistent");
  property p_dr_clear;
    clkEn && rdRhr && !rxDone |=> !dr_r;
  endproperty
  a_dr_clear: assert property (p_dr_clear) else $error("data ready not cleared by read");
  property p_msr_clear;
    clkEn && rdMsr && primed_r && msNow == msPrev_r |=> delta_r == 4'h0 || $changed(msPrev_r);
  endproperty
  a_msr_clear: assert property (p_msr_clear) else $error("modem deltas not cleared");
  property p_scratch;
    clkEn && wrEv && addr == 3'h7 |=> scr_r == $past(dataIn);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch not stored");
  property p_int_out;
    clkEn && anyPend ##1 clkEn && anyPend |=> interruptOut;
  endproperty
  a_int_out: assert property (p_int_out) else $error("interrupt output low while pending");
  c_rx_done: cover property (rxDone && clkEn);
  c_break:   cover property (clkEn && errSet[3]);
  c_tx_load: cover property (clkEn && txLoad);
  c_loop_rx: cover property (clkEn && rxDone && loopMode);
endmodule

// ===== bench/dsc_peer_model.sv
// Serial line partner that sends and captures frames at sixteen clocks a bit.
`timescale 1ns/1ns
module dsc_peer_model #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  input  wire logic ref_clk,
  // Serial line
  input  wire logic serialTransmitOut,
  output logic      serialReceiveIn
);
  initial serialReceiveIn = 1'b1;
  // Sends n bits LSB first then one stop; lowAll keeps every bit low to form a break.
  task automatic send(input logic [8:0] bits, input int n, input logic lowAll);
    int i;
    serialReceiveIn <= 1'b0;
    repeat (BIT_CLKS) @(posedge ref_clk);
    for (i = 0; i <= n; i++) begin
      serialReceiveIn <= (i == n) ? ~lowAll : (bits[i] & ~lowAll);
      repeat (BIT_CLKS) @(posedge ref_clk);
    end
    serialReceiveIn <= 1'b1;
    repeat (BIT_CLKS) @(posedge ref_clk);
  endtask
  // Samples mid-bit, so a one-clock skew in finding the start edge does no harm.
  task automatic capture(input int n, output logic [9:0] bits, output logic ok);
    int i;
    ok = 1'b0;
    bits = 10'h3FF;
    for (i = 0; i < 4000 && !ok; i++) begin
      @(posedge ref_clk);
      ok = (serialTransmitOut === 1'b0);
    end
    repeat (BIT_CLKS / 2) @(posedge ref_clk);
    for (i = 0; i <= n; i++) begin
      repeat (BIT_CLKS) @(posedge ref_clk);
      bits[i] = serialTransmitOut;
    end
  endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the serial channel.
`timescale 1ns/1ns
module tb_top;
  logic       ref_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic       csN     = 1'b1;
  logic [2:0] addr    = 3'h0;
  logic       rdN     = 1'b1;
  logic       wrN     = 1'b1;
  logic [7:0] dataIn  = 8'h00;
  logic [7:0] dataOut;
  logic       irq;
  logic       rxLine;
  logic       txLine;
  logic       ctsN    = 1'b1;
  logic       ringInN = 1'b1;
  logic       dtrN;
  logic       rtsN;
  logic       gpoN;
  logic [7:0] rv;
  int         errCount    = 0;
  int         totalChecks = 0;
  always #5 ref_clk = ~ref_clk;
  dsc_channel u_dsc_channel (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(1'b1), .csN(csN), .addr(addr),
    .rdN(rdN), .wrN(wrN), .dataIn(dataIn), .dataOut(dataOut), .interruptOut(irq), .serialReceiveIn(rxLine),
    .serialTransmitOut(txLine), .ctsN(ctsN), .dsrN(1'b1), .ringInN(ringInN), .carrierInN(1'b1),
    .dtrN(dtrN), .rtsN(rtsN), .generalPurposeOutN(gpoN));
  dsc_peer_model u_dsc_peer_model (.ref_clk(ref_clk), .serialTransmitOut(txLine), .serialReceiveIn(rxLine));
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    csN    <= 1'b0;
    wrN    <= 1'b0;
    addr   <= a;
    dataIn <= d;
    @(posedge ref_clk);
    csN <= 1'b1;
    wrN <= 1'b1;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [2:0] a);
    csN  <= 1'b0;
    rdN  <= 1'b0;
    addr <= a;
    @(posedge ref_clk);
    csN <= 1'b1;
    rdN <= 1'b1;
    @(posedge ref_clk);
    rv = dataOut;
  endtask
  task automatic t_reset;
    rd(dsc_pkg::ADDR_IIR);
    check("iir", rv, 8'h01);
    rd(dsc_pkg::ADDR_LSTAT);
    check("lsr", rv, 8'h60);
    rd(dsc_pkg::ADDR_MSTAT);
    check("msr", rv, 8'h00);
    check("pins", {txLine, dtrN, rtsN, gpoN, irq}, 10'h1E);
    wr(dsc_pkg::ADDR_LFMT, 8'h80);
    wr(dsc_pkg::ADDR_DATA, 8'h01);
    wr(dsc_pkg::ADDR_IER, 8'h00);
    wr(dsc_pkg::ADDR_LFMT, 8'h03);
    $display("reset test done");
  endtask
  task automatic t_modem;
    wr(dsc_pkg::ADDR_SCR, 8'hA6);
    rd(dsc_pkg::ADDR_SCR);
    check("scratch", rv, 8'hA6);
    wr(dsc_pkg::ADDR_MCTL, 8'h0B);
    // The pins are launched at the edge on which the write task returns, so wait one more edge.
    @(posedge ref_clk);
    check("ctl pins", {dtrN, rtsN, gpoN}, 10'h0);
    ctsN <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(dsc_pkg::ADDR_MSTAT);
    check("msr cts", rv, 8'h11);
    ringInN <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ringInN <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(dsc_pkg::ADDR_MSTAT);
    check("msr ring", rv, 8'h14);
    wr(dsc_pkg::ADDR_MCTL, 8'h16);
    rd(dsc_pkg::ADDR_MSTAT);
    check("loop msr", {txLine, rv[7:4]}, 10'h15);
    wr(dsc_pkg::ADDR_MCTL, 8'h00);
    ctsN <= 1'b1;
    $display("modem test done");
  endtask
  task automatic t_tx;
    logic [9:0] got;
    logic       ok;
    wr(dsc_pkg::ADDR_LFMT, 8'h1A);
    fork
      u_dsc_peer_model.capture(8, got, ok);
      begin
        wr(dsc_pkg::ADDR_DATA, 8'h53);
        rd(dsc_pkg::ADDR_LSTAT);
      end
    join
    check("lsr busy", rv, 8'h20);
    check("even7", {ok, got[8:0]}, {1'b1, 1'b1, 1'b0, 7'h53});
    wr(dsc_pkg::ADDR_LFMT, 8'h3B);
    fork
      u_dsc_peer_model.capture(9, got, ok);
      wr(dsc_pkg::ADDR_DATA, 8'h01);
    join
    check("forced0", got, {1'b1, 1'b0, 8'h01});
    repeat (40) @(posedge ref_clk);
    rd(dsc_pkg::ADDR_LSTAT);
    check("lsr idle", rv, 8'h60);
    wr(dsc_pkg::ADDR_LFMT, 8'h43);
    @(posedge ref_clk);
    check("break out", txLine, 1'b0);
    wr(dsc_pkg::ADDR_LFMT, 8'h03);
    @(posedge ref_clk);
    check("break off", txLine, 1'b1);
    $display("transmit test done");
  endtask
  task automatic t_rx;
    int i;
    wr(dsc_pkg::ADDR_LFMT, 8'h0B);
    wr(dsc_pkg::ADDR_IER, 8'h05);
    u_dsc_peer_model.send({1'b0, 8'h3C}, 9, 1'b0);
    for (i = 0; i < 400 && irq !== 1'b1; i++) @(posedge ref_clk);
    check("irq", irq, 1'b1);
    rd(dsc_pkg::ADDR_IIR);
    check("iir ls", rv, 8'h06);
    rd(dsc_pkg::ADDR_LSTAT);
    check("lsr pe", rv, 8'h65);
    rd(dsc_pkg::ADDR_IIR);
    check("iir rx", rv, 8'h04);
    rd(dsc_pkg::ADDR_DATA);
    check("rhr", rv, 8'h3C);
    @(posedge ref_clk);
    check("irq off", irq, 1'b0);
    wr(dsc_pkg::ADDR_LFMT, 8'h03);
    wr(dsc_pkg::ADDR_IER, 8'h00);
    u_dsc_peer_model.send(9'h000, 8, 1'b1);
    rd(dsc_pkg::ADDR_LSTAT);
    check("lsr brk", rv, 8'h79);
    rd(dsc_pkg::ADDR_DATA);
    rd(dsc_pkg::ADDR_LSTAT);
    check("lsr clr", rv, 8'h60);
    u_dsc_peer_model.send(9'h011, 8, 1'b0);
    u_dsc_peer_model.send(9'h022, 8, 1'b0);
    check("irq mask", irq, 1'b0);
    rd(dsc_pkg::ADDR_LSTAT);
    check("lsr oe", rv, 8'h63);
    rd(dsc_pkg::ADDR_DATA);
    check("rhr new", rv, 8'h22);
    wr(dsc_pkg::ADDR_IER, 8'h02);
    @(posedge ref_clk);
    rd(dsc_pkg::ADDR_IIR);
    check("iir tx", rv, 8'h02);
    rd(dsc_pkg::ADDR_IIR);
    check("iir none", rv, 8'h01);
    $display("receive test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    errCount++;
    close_out;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_modem;
    t_tx;
    t_rx;
    close_out;
  end
endmodule
